// [dv/epv_core_model.sv]
// core-side model that asks for exception vectors and keeps each answer
`timescale 1ns/1ns

module epv_core_model
	import epv_pkg::*;
(
	// clock and reset
	input  wire logic     aclk,
	input  wire logic     aresetn,
	// bench command
	input  wire logic     ask,
	output logic          done,
	output epv_vec_t      got,
	// vector port
	output logic          vec_req,
	input  wire logic     vec_ack,
	input  wire epv_vec_t vec_addr
);
	// ------------------------------------------------------------
	// request and capture
	// ------------------------------------------------------------
	// the answer is only trusted on the ack cycle, never later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_req <= 1'b0;
			done    <= 1'b0;
			got     <= 16'h0000;
		end else begin
			vec_req <= ask;
			done    <= vec_ack;
			if (vec_ack)
				got <= vec_addr;
		end
	end
endmodule : epv_core_model

// [dv/epv_decoder_asserts.sv]
// concurrent checks on the vector port of the exception decoder
`timescale 1ns/1ns

module epv_decoder_asserts
	import epv_pkg::*;
(
	// clock and reset
	input wire logic     aclk,
	input wire logic     aresetn,
	// exception requests
	input wire logic     sys_rst_req,
	input wire logic     clkmon_rst_req,
	input wire logic     watchdog_reset_source,
	input wire logic     trap_req,
	input wire logic     software_trap_instr,
	// vector port
	input wire logic     vec_req,
	input wire logic     vec_ack,
	input wire epv_vec_t vec_addr
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wire above_swi = sys_rst_req || clkmon_rst_req || watchdog_reset_source || trap_req;

	chk_ack_follows: assert property (vec_req |=> vec_ack)
		else $error("vector request without acknowledge");
	chk_ack_single: assert property (!vec_req |=> !vec_ack)
		else $error("acknowledge without vector request");
	chk_sys_vector: assert property (vec_req && sys_rst_req |=> vec_addr == 16'hfffe)
		else $error("system reset vector wrong");
	chk_clkmon_vector: assert property (vec_req && !sys_rst_req && clkmon_rst_req
		|=> vec_addr == 16'hfffc) else $error("clock monitor vector wrong");
	chk_wdog_vector: assert property (vec_req && !sys_rst_req && !clkmon_rst_req
		&& watchdog_reset_source |=> vec_addr == 16'hfffa) else $error("watchdog vector wrong");
	chk_trap_order: assert property (vec_req && trap_req && !(sys_rst_req || clkmon_rst_req
		|| watchdog_reset_source) |=> vec_addr == 16'hfff8) else $error("trap vector wrong");
	chk_swi_order: assert property (vec_req && software_trap_instr && !above_swi
		|=> vec_addr == 16'hfff6) else $error("software trap vector wrong");
	chk_addr_holds: assert property (!vec_req |=> $stable(vec_addr))
		else $error("vector changed without request");
endmodule : epv_decoder_asserts

bind epv_decoder epv_decoder_asserts u_asserts (
	.aclk, .aresetn, .sys_rst_req, .clkmon_rst_req, .watchdog_reset_source,
	.trap_req, .software_trap_instr, .vec_req, .vec_ack, .vec_addr
);

// [dv/exception_priority_vector_decoder_bench.sv]
// self-checking bench for the exception priority vector decoder
`timescale 1ns/1ns
`include "epv_defs.svh"

module exception_priority_vector_decoder_bench
	import epv_pkg::*;
();
	logic         aclk = 1'b0, aresetn = 1'b0, ask = 1'b0;
	logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]  s_axi_wdata = 32'h0;
	logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic         special_mode = 1'b0, i_mask = 1'b1, x_mask = 1'b1;
	logic         irq_pin_n = 1'b1, x_masked_pin_request_n = 1'b1;
	logic [120:0] periph_req = '0;
	logic [5:0]   exc = 6'h00;
	logic [1:0]   bresp_seen = 2'h0;
	wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]   s_axi_bresp, s_axi_rresp;
	wire  [31:0]  s_axi_rdata;
	wire          vec_req, vec_ack, int_pending, done;
	wire epv_vec_t vec_addr, got;
	epv_vec_t     vtab [6] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff6};
	int           mismatches = 0, checks_done = 0, cycles = 0;

	always #5 aclk = ~aclk;

	epv_decoder u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .special_mode, .i_mask, .x_mask,
		.irq_pin_n, .x_masked_pin_request_n, .periph_req, .software_trap_instr(exc[1]),
		.debug_entry_request(exc[0]), .trap_req(exc[2]), .sys_rst_req(exc[5]),
		.clkmon_rst_req(exc[4]), .watchdog_reset_source(exc[3]), .vec_req, .vec_ack,
		.vec_addr, .int_pending
	);
	epv_core_model u_core (.aclk, .aresetn, .ask, .done, .got, .vec_req, .vec_ack, .vec_addr);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// a hung handshake ends here rather than stalling the run
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && s_axi_awready !== 1'b1)
			|| (s_axi_wvalid && s_axi_wready !== 1'b1));
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, 32'h0);
	endtask : rdc

	// pins pass a synchroniser and filter, so allow six edges
	task automatic settle();
		repeat (6) @(posedge aclk);
	endtask : settle

	task automatic vec(input epv_vec_t exp);
		@(posedge aclk);
		ask <= 1'b1;
		@(posedge aclk);
		ask <= 1'b0;
		do @(posedge aclk); while (done !== 1'b1);
		chk({16'h0, got}, {16'h0, exp});
	endtask : vec

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(`EPV_OFS_PROMOTE, 32'hf2);
		rdc(`EPV_OFS_LAST_VEC, 32'hfff6);
		vec(16'hfff6);
		chk({31'h0, int_pending}, 32'h0);
		rd(8'h10, d, r);
		chk({30'h0, r}, 32'h3);
		chk(d, 32'h0);
		wr(8'h10, 32'h0);
		chk({30'h0, bresp_seen}, 32'h3);
		for (int i = 0; i < 6; i++) begin
			exc <= 6'h3f >> i;
			vec(vtab[i]);
			chk({31'h0, int_pending}, 32'h1);
		end
		exc <= 6'h00;
		i_mask <= 1'b0;
		x_mask <= 1'b0;
		irq_pin_n <= 1'b0;
		x_masked_pin_request_n <= 1'b0;
		periph_req <= 121'h1 << 120;
		settle();
		vec(16'hfff4);
		x_mask <= 1'b1;
		vec(16'hfff2);
		irq_pin_n <= 1'b1;
		settle();
		vec(16'hfff0);
		periph_req <= 121'h28;
		vec(16'hff0a);
		wr(`EPV_OFS_PROMOTE, 32'h02);
		chk({30'h0, bresp_seen}, 32'h0);
		rdc(`EPV_OFS_PROMOTE, 32'hf2);
		i_mask <= 1'b1;
		wr(`EPV_OFS_PROMOTE, 32'h02);
		rdc(`EPV_OFS_PROMOTE, 32'h02);
		i_mask <= 1'b0;
		periph_req <= (121'h1 << 120) | 121'h6;
		vec(16'hff02);
		periph_req <= (121'h1 << 120) | 121'h4;
		vec(16'hff04);
		i_mask <= 1'b1;
		wr(`EPV_OFS_PROMOTE, 32'hf4);
		i_mask <= 1'b0;
		periph_req <= 121'h2;
		irq_pin_n <= 1'b0;
		settle();
		vec(16'hfff2);
		irq_pin_n <= 1'b1;
		settle();
		periph_req <= 121'h8;
		repeat (2) @(posedge aclk);
		periph_req <= '0;
		vec(16'hff06);
		chk({31'h0, int_pending}, 32'h0);
		rdc(`EPV_OFS_LAST_VEC, 32'hff06);
		special_mode <= 1'b1;
		i_mask <= 1'b1;
		periph_req <= 121'h1 << 120;
		wr(`EPV_OFS_TEST_CTRL, 32'h80);
		wr(`EPV_OFS_TEST_REQ, 32'h02);
		i_mask <= 1'b0;
		vec(16'hff02);
		i_mask <= 1'b1;
		wr(`EPV_OFS_TEST_CTRL, 32'h8f);
		wr(`EPV_OFS_TEST_REQ, 32'hff);
		rdc(`EPV_OFS_TEST_REQ, 32'h07);
		wr(`EPV_OFS_TEST_CTRL, 32'h00);
		periph_req <= 121'h8;
		rdc(`EPV_OFS_TEST_REQ, 32'h08);
		special_mode <= 1'b0;
		wr(`EPV_OFS_TEST_CTRL, 32'h8f);
		rdc(`EPV_OFS_TEST_REQ, 32'h00);
		special_mode <= 1'b1;
		rdc(`EPV_OFS_TEST_CTRL, 32'h00);
		end_of_test();
	end
endmodule : exception_priority_vector_decoder_bench

// [verilog/epv_decoder.sv]
// exception priority decoder with promoted interrupt select and axi4-lite registers
//
// Contract
// R1: promote register reads anytime; writes only land while the i mask is set.
// R2: writing a vector low byte promotes that i source above all others.
// R3: unimplemented or above-f2 values promote the external i pin instead.
// R4: bank f exposes only test bits 2-0; bits 7-3 read zero.
// R5: unimplemented test bank: writes ignored, reads return zero.
// R6: test control and test request registers work only in special mode.
// R7: an active promoted source is offered ahead of other i sources.
// R8: the real-time tick source takes the slot the promoted source vacated.
// R9: priority is evaluated when the core requests the vector.
// R10: sources hold requests until their service routine starts.
// R11: a vanished request yields the last valid vector of the sequence.
// R12: with no request ever pending, the software trap vector is supplied.
// R13: reset causes map to fffe, fffc and fffa respectively.
// R14: order: resets, trap, software/debug, x pin, i pin.
// R15: device i sources fff0 down to ff00, lower address lower priority.
// R16: test bank select picks the bank matching the vector upper nibble.
// R17: override feeds test bits to the decoder; else reads show live inputs.
// R18: test bit 7..0 map to vector low nibbles e,c,a,8,6,4,2,0.
// R19: promote register resets to the external i pin vector.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "epv_defs.svh"

module epv_decoder
	import epv_pkg::*;
(
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// axi4-lite slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// core state
	input  wire logic                special_mode,
	input  wire logic                i_mask,
	input  wire logic                x_mask,
	// external pins, asynchronous, active low
	input  wire logic                irq_pin_n,
	input  wire logic                x_masked_pin_request_n,
	// on-chip requests, same clock
	input  wire logic [120:0]        periph_req,
	input  wire logic                software_trap_instr,
	input  wire logic                debug_entry_request,
	input  wire logic                trap_req,
	input  wire logic                sys_rst_req,
	input  wire logic                clkmon_rst_req,
	input  wire logic                watchdog_reset_source,
	// core vector port
	input  wire logic                vec_req,
	output logic                     vec_ack,
	output epv_vec_t                 vec_addr,
	output logic                     int_pending
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// three stages; the level only moves once stages two and three agree,
	// which filters a single-cycle glitch out of the slow pin
	logic [2:0] ipin_sr;
	logic [2:0] xpin_sr;
	logic       ipin_lvl_r;
	logic       xpin_lvl_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ipin_sr    <= 3'h0;
			xpin_sr    <= 3'h0;
			ipin_lvl_r <= 1'b0;
			xpin_lvl_r <= 1'b0;
		end else begin
			ipin_sr <= {ipin_sr[1:0], ~irq_pin_n};
			xpin_sr <= {xpin_sr[1:0], ~x_masked_pin_request_n};
			if (ipin_sr[1] == ipin_sr[2]) begin
				ipin_lvl_r <= ipin_sr[2];
			end
			if (xpin_sr[1] == xpin_sr[2]) begin
				xpin_lvl_r <= xpin_sr[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic       test_override_enable;
	logic [3:0] test_bank_select;
	epv_req_t   test_request_bits;
	epv_idx_t   promote_vector_bits;
	epv_vec_t   last_vec_r;

	// ----------------------------------------------------------------
	// request vector and test banks
	// ----------------------------------------------------------------
	epv_req_t live_req;
	epv_req_t eff_req;
	epv_req_t impl_mask;
	wire  [6:0] bank_base;
	wire  [7:0] bank_mask;
	wire  [7:0] bank_live;
	wire  [7:0] bank_test;
	wire  [7:0] bank_rd;
	// bit index is vector low byte over two, so bit 7 of a bank is nibble e
	assign live_req  = {5'h00, xpin_lvl_r, ipin_lvl_r, periph_req}; // R18
	assign impl_mask = `EPV_IMPL_MASK;
	assign eff_req   = test_override_enable ? test_request_bits : live_req; // R17
	assign bank_base = {test_bank_select, 3'h0}; // R16
	assign bank_mask = impl_mask[bank_base +: 8] & // R5
		((test_bank_select == `EPV_BANK_TOP) ? `EPV_BANKF_MASK : 8'hff); // R4
	assign bank_live = live_req[bank_base +: 8];
	assign bank_test = test_request_bits[bank_base +: 8];
	assign bank_rd   = (test_override_enable ? bank_test : bank_live) & bank_mask; // R17

	// ----------------------------------------------------------------
	// promotion
	// ----------------------------------------------------------------
	epv_idx_t prom_idx;
	logic [121:0] i_src;
	logic [121:0] perm;
	logic     prom_ok;
	logic     prom_hit;
	assign prom_ok  = (promote_vector_bits <= `EPV_IDX_IPIN) &&
		impl_mask[promote_vector_bits];
	assign prom_idx = prom_ok ? promote_vector_bits : `EPV_IDX_IPIN; // R3
	assign i_src    = eff_req[121:0] & impl_mask[121:0];
	assign prom_hit = i_src[prom_idx]; // R7
	// the tick source moves into the vacated slot; with the pin promoted
	// nothing is vacated and the default order stands
	always_comb begin
		perm = i_src;
		if (prom_idx != `EPV_IDX_IPIN) begin
			perm[prom_idx]        = i_src[`EPV_IDX_RTI]; // R8
			perm[`EPV_IDX_RTI]    = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// priority decoder
	// ----------------------------------------------------------------
	epv_idx_t hi_idx;
	epv_idx_t i_idx;
	logic     i_any;
	// higher bit means higher vector address means higher priority
	always_comb begin
		hi_idx = 7'h00;
		for (int k = 0; k < `EPV_NUM_ISRC; k++) begin
			if (perm[k]) begin
				hi_idx = 7'(k); // R15
			end
		end
	end
	assign i_any = (prom_hit || (|perm)) && !i_mask;
	assign i_idx = prom_hit ? prom_idx : // R2
		((hi_idx == prom_idx) ? `EPV_IDX_RTI : hi_idx);
	epv_vec_t win_vec;
	logic     win_any;
	always_comb begin
		win_any = 1'b1;
		if (sys_rst_req) begin
			win_vec = `EPV_VEC_SYS; // R13
		end else if (clkmon_rst_req) begin
			win_vec = `EPV_VEC_CLKMON; // R13
		end else if (watchdog_reset_source) begin
			win_vec = `EPV_VEC_WDOG; // R13
		end else if (trap_req) begin
			win_vec = `EPV_VEC_TRAP; // R14
		end else if (software_trap_instr || debug_entry_request) begin
			win_vec = `EPV_VEC_SWI; // R14
		end else if (eff_req[`EPV_IDX_XPIN] && !x_mask) begin
			win_vec = `EPV_VEC_XPIN; // R14
		end else if (i_any) begin
			win_vec = {`EPV_VEC_PAGE, i_idx, 1'b0}; // R14
		end else begin
			win_vec = `EPV_VEC_SWI;
			win_any = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// vector port
	// ----------------------------------------------------------------
	// sampled on the request edge, so a later higher source still wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_ack     <= 1'b0;
			vec_addr    <= `EPV_VEC_SWI;
			int_pending <= 1'b0;
			last_vec_r  <= `EPV_VEC_SWI; // R12
		end else begin
			vec_ack     <= vec_req;
			int_pending <= win_any;
			if (win_any) begin
				last_vec_r <= win_vec; // R11
			end
			if (vec_req) begin
				vec_addr <= win_any ? win_vec : last_vec_r; // R9 R10 R11
			end
		end
	end

	// ----------------------------------------------------------------
	// axi write channel
	// ----------------------------------------------------------------
	logic [7:0]  wr_addr_r;
	logic [31:0] wr_data_r;
	logic        wr_lane0_r;
	logic        aw_have_r;
	logic        w_have_r;
	wire         aw_take = s_axi_awvalid && s_axi_awready;
	wire         w_take  = s_axi_wvalid && s_axi_wready;
	wire         do_wr   = aw_have_r && w_have_r && !s_axi_bvalid;
	wire         b_done  = s_axi_bvalid && s_axi_bready;
	wire wr_ctrl = do_wr && wr_lane0_r && (wr_addr_r == `EPV_OFS_TEST_CTRL);
	wire wr_treq = do_wr && wr_lane0_r && (wr_addr_r == `EPV_OFS_TEST_REQ);
	wire wr_prom = do_wr && wr_lane0_r && (wr_addr_r == `EPV_OFS_PROMOTE);
	wire wr_map  = (wr_addr_r == `EPV_OFS_TEST_CTRL) ||
		(wr_addr_r == `EPV_OFS_TEST_REQ) || (wr_addr_r == `EPV_OFS_PROMOTE) ||
		(wr_addr_r == `EPV_OFS_LAST_VEC);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EPV_RESP_OKAY;
			wr_addr_r     <= 8'h00;
			wr_data_r     <= 32'h0000_0000;
			wr_lane0_r    <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !aw_take && !s_axi_bvalid;
			s_axi_wready  <= !w_have_r && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_have_r <= 1'b1;
				wr_addr_r <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (w_take) begin
				w_have_r   <= 1'b1;
				wr_data_r  <= s_axi_wdata;
				wr_lane0_r <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `EPV_RESP_OKAY : `EPV_RESP_DECERR;
			end else if (b_done) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// register updates
	// ----------------------------------------------------------------
	wire ovr_wr_ok  = special_mode && i_mask && x_mask;
	wire treq_wr_ok = special_mode && test_override_enable && i_mask; // R6
	wire [7:0] treq_new = (bank_test & ~bank_mask) | (wr_data_r[7:0] & bank_mask);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_override_enable <= `EPV_CTRL_RST;
			test_bank_select     <= 4'h0;
		end else if (wr_ctrl && special_mode) begin // R6
			test_bank_select <= wr_data_r[`EPV_BANK_MSB:0];
			if (ovr_wr_ok) begin
				test_override_enable <= wr_data_r[`EPV_OVR_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_request_bits <= '0;
		end else if (wr_treq && treq_wr_ok) begin
			test_request_bits[bank_base +: 8] <= treq_new; // R4 R5
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			promote_vector_bits <= `EPV_PROMOTE_RST; // R19
		end else if (wr_prom && i_mask) begin
			promote_vector_bits <= wr_data_r[7:1]; // R1 R2
		end
	end

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
	wire       ar_take = s_axi_arvalid && s_axi_arready;
	wire [7:0] ctrl_rd = special_mode ? // R6
		{test_override_enable, 3'h0, test_bank_select} : 8'h00;
	wire [7:0] treq_rd = special_mode ? bank_rd : 8'h00; // R6
	wire       rd_map  = (rd_addr == `EPV_OFS_TEST_CTRL) ||
		(rd_addr == `EPV_OFS_TEST_REQ) || (rd_addr == `EPV_OFS_PROMOTE) ||
		(rd_addr == `EPV_OFS_LAST_VEC);
	wire [31:0] rd_word =
		(rd_addr == `EPV_OFS_TEST_CTRL) ? {24'h0, ctrl_rd} :
		(rd_addr == `EPV_OFS_TEST_REQ)  ? {24'h0, treq_rd} :
		(rd_addr == `EPV_OFS_PROMOTE)   ? {24'h0, promote_vector_bits, 1'b0} : // R1
		(rd_addr == `EPV_OFS_LAST_VEC)  ? {16'h0, last_vec_r} : 32'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `EPV_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_map ? `EPV_RESP_OKAY : `EPV_RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : epv_decoder

// [verilog/epv_defs.svh]
// constants for the exception priority vector decoder
`ifndef EPV_DEFS_SVH
`define EPV_DEFS_SVH

// register byte offsets
`define EPV_OFS_TEST_CTRL  8'h00
`define EPV_OFS_TEST_REQ   8'h04
`define EPV_OFS_PROMOTE    8'h08
`define EPV_OFS_LAST_VEC   8'h0c

// test control fields
`define EPV_OVR_BIT        7
`define EPV_BANK_MSB       3

// reset values
`define EPV_PROMOTE_RST    7'h79
`define EPV_CTRL_RST       1'b0

// exception vectors
`define EPV_VEC_SYS        16'hfffe
`define EPV_VEC_CLKMON     16'hfffc
`define EPV_VEC_WDOG       16'hfffa
`define EPV_VEC_TRAP       16'hfff8
`define EPV_VEC_SWI        16'hfff6
`define EPV_VEC_XPIN       16'hfff4
`define EPV_VEC_PAGE       8'hff

// request bit indices (vector low byte divided by two)
`define EPV_IDX_IPIN       7'h79
`define EPV_IDX_XPIN       7'h7a
`define EPV_IDX_RTI        7'h78
`define EPV_NUM_ISRC       122
`define EPV_NUM_PERIPH     121

// implemented request bits, and bank f window
`define EPV_IMPL_MASK      128'h07ff_ffff_ffff_ffff_ffff_ffff_ffff_ffff
`define EPV_BANK_TOP       4'hf
`define EPV_BANKF_MASK     8'h07

// axi responses
`define EPV_RESP_OKAY      2'h0
`define EPV_RESP_DECERR    2'h3

`endif

// [verilog/epv_pkg.sv]
// types shared by the exception priority vector decoder
package epv_pkg;

	typedef logic [127:0] epv_req_t;
	typedef logic [15:0]  epv_vec_t;
	typedef logic [6:0]   epv_idx_t;

endpackage : epv_pkg
